// file: src/dul_ctrl.sv
/*
 dac update and load control: decodes command frames, runs the load
 strobe, load mask, reference setup, reset pin and power-on reset.
 assumes an outside serial front end hands over one complete frame
 per frame_valid_i pulse, and that all pins are synchronous to clk_i.
*/
`timescale 1ns/1ns
`include "dul_params.svh"
module dul_ctrl #(
    parameter int POR_CYC = `DUL_POR_CYC,
    parameter int RST_MIN_CYC = `DUL_RST_MIN_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic frame_valid_i,
    input wire logic [`DUL_FRAME_W-1:0] frame_i,
    input wire logic load_strobe_n_i,
    input wire logic reset_n_i,
    input wire logic reset_level_select_i,
    output logic [`DUL_NCH-1:0][`DUL_DATA_W-1:0] dac_code_o,
    output logic [`DUL_NCH-1:0][`DUL_DATA_W-1:0] input_code_o,
    output logic [`DUL_NCH-1:0] load_mask_o,
    output logic ref_off_o,
    output logic por_busy_o,
    output logic pin_reset_o,
    output dul_pkg::dul_cmd_t last_cmd_o
);
    localparam logic [7:0] POR_LAST = 8'(POR_CYC - 1);
    localparam logic [3:0] RST_LAST = 4'(RST_MIN_CYC - 1);
    localparam logic [3:0] LOW_SAT = 4'hF;

    dul_pkg::dul_dec_t dec;
    dul_pkg::dul_state_t state_ff;
    dul_pkg::dul_state_t nxt_state;
    dul_pkg::dul_cmd_t last_cmd_ff;
    dul_pkg::dul_cmd_t nxt_last_cmd;
    logic [7:0] por_cnt_ff;
    logic [7:0] nxt_por_cnt;
    logic [3:0] low_cnt_ff;
    logic [3:0] nxt_low_cnt;
    logic [`DUL_NCH-1:0] mask_ff;
    logic [`DUL_NCH-1:0] nxt_mask;
    logic ref_off_ff;
    logic nxt_ref_off;
    logic strobe_prev_ff;

    logic in_run;
    logic in_por;
    logic pin_low;
    logic pin_hit;
    logic upd_ok;
    logic take;
    logic is_mask;
    logic is_ref;
    logic is_sw_rst;
    logic strobe_fall;
    logic clr_any;
    logic [`DUL_DATA_W-1:0] clr_code;
    logic por_done;

    dul_dec u_dec (
        .frame_valid_i(frame_valid_i),
        .frame_i(frame_i),
        .dec_o(dec)
    );

    assign in_run = state_ff == dul_pkg::st_run;
    assign in_por = state_ff == dul_pkg::st_por;
    assign por_done = por_cnt_ff == POR_LAST;
    assign pin_low = !reset_n_i;

    // pin reset counts only in run state, so power-on hides it
    assign pin_hit = in_run
                   && pin_low
                   && (low_cnt_ff >= RST_LAST); // RQ12 RQ15

    // a low reset pin freezes every update path
    assign upd_ok = in_run && !pin_low; // RQ13
    assign take = upd_ok && dec.valid;

    assign is_mask = take && (dec.cmd == dul_pkg::cmd_mask); // RQ8
    assign is_ref = take && (dec.cmd == dul_pkg::cmd_ref); // RQ17
    assign is_sw_rst = take && (dec.cmd == dul_pkg::cmd_sw_rst); // RQ14

    // strobe edges during power-on or pin reset are dropped
    assign strobe_fall = strobe_prev_ff
                       && !load_strobe_n_i
                       && upd_ok; // RQ5 RQ15

    assign clr_any = !in_run || pin_hit; // RQ12 RQ16
    assign clr_code = reset_level_select_i ? `DUL_CODE_MID
                                           : `DUL_CODE_ZERO; // RQ16

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            dul_pkg::st_por: begin
                if (por_done) begin
                    nxt_state = dul_pkg::st_run;
                end
            end
            dul_pkg::st_run: begin
                if (is_sw_rst) begin
                    nxt_state = dul_pkg::st_por; // RQ14
                end else if (pin_hit) begin
                    nxt_state = dul_pkg::st_pin_rst; // RQ12
                end
            end
            dul_pkg::st_pin_rst: begin
                if (reset_n_i) begin
                    nxt_state = dul_pkg::st_run; // RQ13
                end
            end
            default: begin
                nxt_state = dul_pkg::st_por;
            end
        endcase
    end

    assign nxt_por_cnt = in_por ? 8'(por_cnt_ff + 8'h01) : 8'h00;

    // saturating so a long reset pulse cannot wrap the count
    assign nxt_low_cnt = !(in_run && pin_low) ? 4'h0 :
                         (low_cnt_ff == LOW_SAT) ? low_cnt_ff :
                         4'(low_cnt_ff + 4'h1);

    assign nxt_mask = is_sw_rst ? `DUL_MASK_RST :
                      is_mask ? dec.mask : mask_ff; // RQ8 RQ9 RQ14
    assign nxt_ref_off = is_sw_rst ? `DUL_REF_RST :
                         is_ref ? dec.ref_off : ref_off_ff; // RQ17
    assign nxt_last_cmd = take ? dec.cmd : last_cmd_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= dul_pkg::st_por;
            por_cnt_ff <= 8'h00;
            low_cnt_ff <= 4'h0;
        end else begin
            state_ff <= nxt_state;
            por_cnt_ff <= nxt_por_cnt;
            low_cnt_ff <= nxt_low_cnt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_ff <= `DUL_MASK_RST; // RQ10
            ref_off_ff <= `DUL_REF_RST; // RQ17
            last_cmd_ff <= dul_pkg::cmd_nop;
            strobe_prev_ff <= 1'h1;
        end else begin
            mask_ff <= nxt_mask;
            ref_off_ff <= nxt_ref_off;
            last_cmd_ff <= nxt_last_cmd;
            strobe_prev_ff <= load_strobe_n_i;
        end
    end

    for (genvar i = 0; i < `DUL_NCH; i++) begin : g_ch
        logic hit;
        dul_pkg::dul_chan_ctl_t ctl;

        assign hit = take && dec.sel[i];
        assign ctl.wr_in = hit
                         && (dec.cmd == dul_pkg::cmd_wr_in
                             || dec.cmd == dul_pkg::cmd_wr_upd); // RQ3 RQ4
        // strobe low makes write-input immediate, mask not consulted
        assign ctl.wr_dac = hit
                          && (dec.cmd == dul_pkg::cmd_wr_upd
                              || (dec.cmd == dul_pkg::cmd_wr_in
                                  && !load_strobe_n_i)); // RQ3 RQ7 RQ11
        assign ctl.copy = (hit && dec.cmd == dul_pkg::cmd_upd)
                        || (strobe_fall && !mask_ff[i]); // RQ5 RQ6 RQ10
        assign ctl.clear = clr_any;
        assign ctl.data = dec.data;

        dul_chan u_ch (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .ctl_i(ctl),
            .clear_code_i(clr_code),
            .in_code_o(input_code_o[i]),
            .dac_code_o(dac_code_o[i])
        );
    end

    assign load_mask_o = mask_ff;
    assign ref_off_o = ref_off_ff;
    assign por_busy_o = in_por;
    assign pin_reset_o = state_ff == dul_pkg::st_pin_rst;
    assign last_cmd_o = last_cmd_ff;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_load(logic go, int ch);
        go |=> dac_code_o[ch] == $past(dec.data)
            && input_code_o[ch] == $past(dec.data);
    endproperty

    write_low_a: assert property ( // RQ3
        p_load(take && dec.sel[1] && dec.cmd == dul_pkg::cmd_wr_in
               && !load_strobe_n_i, 1))
        else $error("write-input with strobe low missed the dac");

    write_high_a: assert property ( // RQ4
        take && dec.sel[1] && dec.cmd == dul_pkg::cmd_wr_in
        && load_strobe_n_i
        |=> $stable(dac_code_o[1])
            && input_code_o[1] == $past(dec.data))
        else $error("write-input with strobe high touched the dac");

    fall_copy_a: assert property ( // RQ5
        strobe_fall && !mask_ff[2] && !dec.valid
        |=> dac_code_o[2] == $past(input_code_o[2]))
        else $error("strobe edge did not copy an unmasked channel");

    update_cmd_a: assert property ( // RQ6
        take && dec.sel[0] && dec.cmd == dul_pkg::cmd_upd
        |=> dac_code_o[0] == $past(input_code_o[0])
            && $stable(input_code_o[0]))
        else $error("update command copied wrongly");

    write_update_a: assert property ( // RQ7
        p_load(take && dec.sel[3] && dec.cmd == dul_pkg::cmd_wr_upd, 3))
        else $error("write-and-update missed a register");

    mask_load_a: assert property ( // RQ8
        take && dec.cmd == dul_pkg::cmd_mask
        |=> load_mask_o == $past(frame_i[3:0]))
        else $error("mask register not loaded from frame bits 3..0");

    masked_hold_a: assert property ( // RQ10
        strobe_fall && mask_ff[2] && !dec.valid
        |=> $stable(dac_code_o[2]))
        else $error("masked channel followed the strobe");

    held_low_a: assert property ( // RQ11
        take && dec.sel[2] && mask_ff[2] && !load_strobe_n_i
        && dec.cmd == dul_pkg::cmd_wr_in
        |=> dac_code_o[2] == $past(dec.data))
        else $error("mask blocked write-input with strobe low");

    pin_clear_a: assert property ( // RQ12
        pin_hit |=> dac_code_o == {`DUL_NCH{$past(clr_code)}}
            && pin_reset_o)
        else $error("reset pin did not clear the outputs");

    pin_block_a: assert property ( // RQ13
        pin_reset_o && $past(pin_reset_o)
        && reset_level_select_i == $past(reset_level_select_i)
        |=> $stable(dac_code_o) && $stable(input_code_o))
        else $error("output changed while reset pin held low");

    sw_reset_a: assert property ( // RQ14
        is_sw_rst |=> por_busy_o && load_mask_o == `DUL_MASK_RST
            && ref_off_o == `DUL_REF_RST ##1 dac_code_o[1] == $past(clr_code))
        else $error("software reset did not restore power-on state");

    por_ignore_a: assert property ( // RQ15
        por_busy_o |=> !pin_reset_o && dac_code_o[0] == $past(clr_code))
        else $error("activity during power-on reset took effect");

    power_code_a: assert property ( // RQ16
        por_busy_o && !reset_level_select_i |=> dac_code_o[3] == 10'h000)
        else $error("power-up code is not zero scale");

    ref_load_a: assert property ( // RQ17
        take && dec.cmd == dul_pkg::cmd_ref
        |=> ref_off_o == $past(frame_i[0]))
        else $error("reference setup bit not stored");

    // every code output is a flop, so checks look one edge ahead
    last_cmd_a: assert property ( // RQ2
        take |=> last_cmd_o == $past(dec.cmd))
        else $error("last command code not recorded");

    refused_frame_a: assert property ( // RQ13 RQ15
        dec.valid && !take
        |=> $stable(load_mask_o) && $stable(ref_off_o)
            && $stable(last_cmd_o))
        else $error("refused frame changed a register");

    power_cmd_a: assert property ( // RQ2
        take && dec.cmd == dul_pkg::cmd_pwr && !strobe_fall
        |=> $stable(dac_code_o) && $stable(input_code_o))
        else $error("power-down code touched a channel");

    ref_hold_a: assert property ( // RQ17
        !is_ref && !is_sw_rst |=> $stable(ref_off_o))
        else $error("reference bit changed without its command");

    mask_hold_a: assert property ( // RQ8
        !is_mask && !is_sw_rst |=> $stable(load_mask_o))
        else $error("mask changed without its command");

    pin_stay_a: assert property ( // RQ13
        pin_reset_o && !reset_n_i |=> pin_reset_o)
        else $error("pin reset left while the pin is low");

    pin_exit_a: assert property ( // RQ13
        pin_reset_o && reset_n_i |=> !pin_reset_o && !por_busy_o)
        else $error("pin reset did not return to run");

    pin_quiet_a: assert property ( // RQ13 RQ15
        (pin_reset_o || por_busy_o) |-> !take && !strobe_fall)
        else $error("update accepted during a reset");

    pin_level_a: assert property ( // RQ12
        pin_reset_o |=> dac_code_o == {`DUL_NCH{$past(clr_code)}}
            && input_code_o == {`DUL_NCH{$past(clr_code)}})
        else $error("pin reset let a code drift from the clear code");

    all_follow_a: assert property ( // RQ5 RQ10
        strobe_fall && load_mask_o == 4'h0 && !dec.valid
        |=> dac_code_o == $past(input_code_o))
        else $error("strobe edge missed a channel with mask clear");

    idle_hold_a: assert property ( // RQ16
        in_run && reset_n_i && !dec.valid && !strobe_fall
        |=> $stable(dac_code_o) && $stable(input_code_o))
        else $error("code changed with no write, strobe or reset");

    sel_only_a: assert property ( // RQ3 RQ7
        take && dec.cmd == dul_pkg::cmd_wr_upd && !dec.sel[0]
        && !strobe_fall
        |=> $stable(dac_code_o[0]) && $stable(input_code_o[0]))
        else $error("write reached a channel that was not selected");

    upd_input_a: assert property ( // RQ6
        take && dec.cmd == dul_pkg::cmd_upd |=> $stable(input_code_o))
        else $error("update command wrote an input register");

    por_input_a: assert property ( // RQ15 RQ16
        por_busy_o |=> input_code_o == {`DUL_NCH{$past(clr_code)}})
        else $error("input register escaped the power-on clear");

    por_regs_a: assert property ( // RQ10 RQ14
        por_busy_o |-> load_mask_o == `DUL_MASK_RST
            && ref_off_o == `DUL_REF_RST)
        else $error("mask or reference bit set during power-on");

    // lower bound only: the first interval trails a reset of any length
    por_len_a: assert property ( // RQ16
        $fell(por_busy_o) |-> $past(por_busy_o, POR_CYC))
        else $error("power-on interval ended early");

    deferred_c: cover property (
        take && dec.cmd == dul_pkg::cmd_wr_in && load_strobe_n_i
        ##[1:20] strobe_fall);
    masked_c: cover property (strobe_fall && mask_ff != 4'h0);
    pin_reset_c: cover property (pin_hit ##1 pin_reset_o ##[1:10] in_run);
    sw_reset_c: cover property (is_sw_rst ##1 por_busy_o);
    zero_por_c: cover property (
        por_busy_o && !reset_level_select_i);
endmodule

// file: src/dul_params.svh
/*
 constants of the dac update and load control block: frame field
 positions, reset values, clear codes and timing counts.
 assumes a 20 MHz system clock and a 24-bit command frame source.
*/
`ifndef DUL_PARAMS_SVH
`define DUL_PARAMS_SVH
// Function
// [RQ1] master sends command byte, data high byte, data low byte as one frame
// [RQ2] frame bits 23..20 are the command, 19..16 the channel select
// [RQ3] write-input with strobe low loads input and dac register at once
// [RQ4] write-input with strobe high loads only the input register
// [RQ5] strobe falling edge copies input to dac on each unmasked channel
// [RQ6] update command copies input to dac, input unchanged, any strobe level
// [RQ7] write-and-update loads input and dac register, any strobe level
// [RQ8] mask command loads frame bits 3..0 into mask, ignores channel select
// [RQ9] mask bit 3 is channel d, down to bit 0 for channel a
// [RQ10] mask resets to zero; a set bit makes its channel ignore the strobe
// [RQ11] strobe held low: write-input updates dac regardless of mask
// [RQ12] reset pin low clears outputs to selected code; held 30 ns least
// [RQ13] updates blocked while reset pin low; cleared value held afterwards
// [RQ14] software reset command returns everything to the power-on state; last_cmd_o keeps cmd_sw_rst, not cmd_nop
// [RQ15] strobe and reset pin activity ignored during power-on reset
// [RQ16] power-up code is zero or midscale by reset level select pin
// [RQ17] reference command stores frame bit 0: zero on, one off

`define DUL_NCH 4
`define DUL_DATA_W 10
`define DUL_FRAME_W 24
`define DUL_CMD_MSB 23
`define DUL_CMD_LSB 20
`define DUL_ADDR_MSB 19
`define DUL_ADDR_LSB 16
`define DUL_DATA_MSB 15
`define DUL_DATA_LSB 6
`define DUL_MASK_MSB 3
`define DUL_MASK_LSB 0
`define DUL_REF_BIT 0
`define DUL_MASK_RST 4'h0
`define DUL_REF_RST 1'h0
`define DUL_CODE_ZERO 10'h000
`define DUL_CODE_MID 10'h200

`define DUL_CLK_PERIOD_NS 50
`define DUL_POR_TIME_NS 1000
`define DUL_POR_CYC \
    ((`DUL_POR_TIME_NS + `DUL_CLK_PERIOD_NS - 1) / `DUL_CLK_PERIOD_NS)
`define DUL_RST_MIN_NS 30
`define DUL_RST_MIN_CYC \
    ((`DUL_RST_MIN_NS + `DUL_CLK_PERIOD_NS - 1) / `DUL_CLK_PERIOD_NS)
`endif

// file: src/dul_pkg.sv
/*
 types of the dac update and load control block.
 assumes dul_params.svh is on the include path.
*/
`include "dul_params.svh"
package dul_pkg;
    typedef enum logic [3:0] {
        cmd_nop = 4'h0,
        cmd_wr_in = 4'h1,
        cmd_upd = 4'h2,
        cmd_wr_upd = 4'h3,
        cmd_pwr = 4'h4,
        cmd_mask = 4'h5,
        cmd_sw_rst = 4'h6,
        cmd_ref = 4'h7
    } dul_cmd_t;

    typedef enum logic [1:0] {
        st_por = 2'h0,
        st_run = 2'h1,
        st_pin_rst = 2'h2
    } dul_state_t;

    typedef struct packed {
        logic valid;
        dul_cmd_t cmd;
        logic [`DUL_NCH-1:0] sel;
        logic [`DUL_DATA_W-1:0] data;
        logic [`DUL_NCH-1:0] mask;
        logic ref_off;
    } dul_dec_t;

    typedef struct packed {
        logic wr_in;
        logic wr_dac;
        logic copy;
        logic clear;
        logic [`DUL_DATA_W-1:0] data;
    } dul_chan_ctl_t;
endpackage

// file: src/dul_dec.sv
/*
 frame field decoder: splits a 24-bit command frame into its fields.
 assumes the frame is complete when frame_valid_i is high.
*/
`timescale 1ns/1ns
`include "dul_params.svh"
module dul_dec (
    input wire logic frame_valid_i,
    input wire logic [`DUL_FRAME_W-1:0] frame_i,
    output dul_pkg::dul_dec_t dec_o
);
    assign dec_o.valid = frame_valid_i;
    assign dec_o.cmd =
        dul_pkg::dul_cmd_t'(frame_i[`DUL_CMD_MSB:`DUL_CMD_LSB]); // RQ2
    assign dec_o.sel = frame_i[`DUL_ADDR_MSB:`DUL_ADDR_LSB]; // RQ2
    assign dec_o.data = frame_i[`DUL_DATA_MSB:`DUL_DATA_LSB];
    // channel select plays no part here, so it is ignored
    assign dec_o.mask = frame_i[`DUL_MASK_MSB:`DUL_MASK_LSB]; // RQ8
    assign dec_o.ref_off = frame_i[`DUL_REF_BIT]; // RQ17
endmodule

// file: src/dul_chan.sv
/*
 one channel: input register and dac register with their load paths.
 when the controller raises wr_dac and copy together, wr_dac wins.
*/
`timescale 1ns/1ns
`include "dul_params.svh"
module dul_chan (
    input wire logic clk_i,
    input wire logic rst_i,
    input dul_pkg::dul_chan_ctl_t ctl_i,
    input wire logic [`DUL_DATA_W-1:0] clear_code_i,
    output logic [`DUL_DATA_W-1:0] in_code_o,
    output logic [`DUL_DATA_W-1:0] dac_code_o
);
    logic [`DUL_DATA_W-1:0] in_code_ff;
    logic [`DUL_DATA_W-1:0] dac_code_ff;
    logic [`DUL_DATA_W-1:0] nxt_in_code;
    logic [`DUL_DATA_W-1:0] nxt_dac_code;

    // clear wins over every load so a reset cannot be overwritten
    assign nxt_in_code = ctl_i.clear ? clear_code_i :
                         ctl_i.wr_in ? ctl_i.data : in_code_ff;
    assign nxt_dac_code = ctl_i.clear ? clear_code_i :
                          ctl_i.wr_dac ? ctl_i.data :
                          ctl_i.copy ? in_code_ff : dac_code_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_code_ff <= `DUL_CODE_ZERO;
            dac_code_ff <= `DUL_CODE_ZERO;
        end else begin
            in_code_ff <= nxt_in_code;
            dac_code_ff <= nxt_dac_code;
        end
    end

    assign in_code_o = in_code_ff;
    assign dac_code_o = dac_code_ff;
endmodule

// file: tb/dul_master.sv
/*
 frame source model: stands in for the serial bus master and its front
 end, handing one complete 24-bit command frame per valid pulse.
 assumes the testbench calls send from its own process, off the edge.
*/
`timescale 1ns/1ns
`include "dul_params.svh"
module dul_master (
    input wire logic clk_i,
    output logic frame_valid_o,
    output logic [`DUL_FRAME_W-1:0] frame_o
);
    initial begin
        frame_valid_o = 1'b0;
        frame_o = 24'h5A5A5A;
    end

    // one frame, then the bus is released; no back-to-back bursts here
    task automatic send(input logic [3:0] cmd, input logic [3:0] sel,
                        input logic [9:0] code, input logic [5:0] low);
        @(posedge clk_i);
        #1;
        frame_o = {cmd, sel, code, low};
        frame_valid_o = 1'b1;
        @(posedge clk_i);
        #1;
        frame_valid_o = 1'b0;
        // a released bus must not keep showing the last frame
        frame_o = ~frame_o;
    endtask
endmodule

// file: tb/testbench.sv
/*
 self-checking testbench of the dac update and load control block.
 assumes dul_master as frame source and a 20 MHz clock.
*/
`timescale 1ns/1ns
`include "dul_params.svh"
module testbench;
    localparam int POR = 6;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic frame_valid;
    logic [`DUL_FRAME_W-1:0] frame;
    logic load_strobe_n = 1'b1;
    logic reset_n = 1'b1;
    logic rsel = 1'b1;
    logic [`DUL_NCH-1:0][`DUL_DATA_W-1:0] dac_code;
    logic [`DUL_NCH-1:0][`DUL_DATA_W-1:0] input_code;
    logic [`DUL_NCH-1:0] load_mask;
    logic ref_off;
    logic por_busy;
    logic pin_reset;
    dul_pkg::dul_cmd_t last_cmd;
    int miscompares = 0;
    int total_checks = 0;

    always #25 clk_i = ~clk_i;

    dul_master dul_master_i (
        .clk_i(clk_i),
        .frame_valid_o(frame_valid),
        .frame_o(frame)
    );

    dul_ctrl #(.POR_CYC(POR), .RST_MIN_CYC(1)) dul_ctrl_i (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .frame_valid_i(frame_valid),
        .frame_i(frame),
        .load_strobe_n_i(load_strobe_n),
        .reset_n_i(reset_n),
        .reset_level_select_i(rsel),
        .dac_code_o(dac_code),
        .input_code_o(input_code),
        .load_mask_o(load_mask),
        .ref_off_o(ref_off),
        .por_busy_o(por_busy),
        .pin_reset_o(pin_reset),
        .last_cmd_o(last_cmd)
    );

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic set_pins(input logic strobe_n, input logic rst_n);
        @(posedge clk_i);
        #1;
        load_strobe_n = strobe_n;
        reset_n = rst_n;
    endtask

    task automatic chk_ch(input int i, input logic [9:0] in_exp,
                          input logic [9:0] dac_exp);
        chk($sformatf("input_code[%0d]", i), input_code[i], in_exp);
        chk($sformatf("dac_code[%0d]", i), dac_code[i], dac_exp);
    endtask

    // bounded wait for the power-on interval to end
    task automatic wait_ready;
        int k;
        k = 0;
        while (por_busy !== 1'b0 && k < 100) begin
            tick(1);
            k++;
        end
        chk("por_busy", por_busy, 0);
    endtask

    task automatic t_power_up;
        for (int i = 0; i < 4; i++) chk_ch(i, 10'h200, 10'h200);
        chk("load_mask", load_mask, 4'h0);
        chk("ref_off", ref_off, 1'h0);
        $display("done: power up");
    endtask

    task automatic t_writes;
        dul_master_i.send(dul_pkg::cmd_wr_in, 4'h2, 10'h155, 6'h00);
        chk_ch(1, 10'h155, 10'h200);
        set_pins(1'b0, 1'b1);
        dul_master_i.send(dul_pkg::cmd_wr_in, 4'h2, 10'h0AA, 6'h00);
        chk_ch(1, 10'h0AA, 10'h0AA);
        set_pins(1'b1, 1'b1);
        dul_master_i.send(dul_pkg::cmd_wr_in, 4'h1, 10'h123, 6'h00);
        dul_master_i.send(dul_pkg::cmd_upd, 4'h1, 10'h3FF, 6'h00);
        chk_ch(0, 10'h123, 10'h123);
        dul_master_i.send(dul_pkg::cmd_wr_upd, 4'h8, 10'h3FF, 6'h00);
        chk_ch(3, 10'h3FF, 10'h3FF);
        chk("last_cmd", last_cmd, dul_pkg::cmd_wr_upd);
        dul_master_i.send(dul_pkg::cmd_pwr, 4'hF, 10'h000, 6'h3F);
        chk_ch(3, 10'h3FF, 10'h3FF);
        chk("last_cmd", last_cmd, dul_pkg::cmd_pwr);
        $display("done: write commands");
    endtask

    task automatic t_mask;
        dul_master_i.send(dul_pkg::cmd_mask, 4'hF, 10'h000, 6'h04);
        chk("load_mask", load_mask, 4'h4);
        for (int i = 0; i < 4; i++) begin
            dul_master_i.send(dul_pkg::cmd_wr_in, 4'(1 << i),
                              10'(10'h040 + i), 6'h00);
        end
        set_pins(1'b0, 1'b1);
        tick(1);
        for (int i = 0; i < 4; i++) begin
            chk_ch(i, 10'(10'h040 + i),
                   (i == 2) ? 10'h200 : 10'(10'h040 + i));
        end
        dul_master_i.send(dul_pkg::cmd_wr_in, 4'h4, 10'h0F0, 6'h00);
        chk_ch(2, 10'h0F0, 10'h0F0);
        set_pins(1'b1, 1'b1);
        $display("done: load mask");
    endtask

    task automatic t_ref;
        dul_master_i.send(dul_pkg::cmd_ref, 4'h0, 10'h000, 6'h01);
        chk("ref_off", ref_off, 1'h1);
        dul_master_i.send(dul_pkg::cmd_ref, 4'hF, 10'h3FF, 6'h3E);
        chk("ref_off", ref_off, 1'h0);
        $display("done: reference setup");
    endtask

    task automatic t_pin_reset;
        rsel = 1'b0;
        set_pins(1'b1, 1'b0);
        tick(2);
        chk("pin_reset", pin_reset, 1'h1);
        dul_master_i.send(dul_pkg::cmd_wr_upd, 4'hF, 10'h3FF, 6'h00);
        for (int i = 0; i < 4; i++) chk_ch(i, 10'h000, 10'h000);
        set_pins(1'b1, 1'b1);
        tick(2);
        for (int i = 0; i < 4; i++) chk_ch(i, 10'h000, 10'h000);
        $display("done: reset pin");
    endtask

    task automatic t_sw_reset;
        dul_master_i.send(dul_pkg::cmd_mask, 4'h0, 10'h000, 6'h0F);
        chk("load_mask", load_mask, 4'hF);
        dul_master_i.send(dul_pkg::cmd_ref, 4'h0, 10'h000, 6'h01);
        chk("ref_off", ref_off, 1'h1);
        dul_master_i.send(dul_pkg::cmd_wr_upd, 4'h1, 10'h111, 6'h00);
        rsel = 1'b1;
        dul_master_i.send(dul_pkg::cmd_sw_rst, 4'h0, 10'h000, 6'h00);
        chk("por_busy", por_busy, 1'h1);
        // pin activity inside the power-on interval must leave no trace
        set_pins(1'b0, 1'b0);
        set_pins(1'b1, 1'b1);
        wait_ready();
        chk("pin_reset", pin_reset, 1'h0);
        for (int i = 0; i < 4; i++) chk_ch(i, 10'h200, 10'h200);
        chk("load_mask", load_mask, 4'h0);
        chk("ref_off", ref_off, 1'h0);
        rsel = 1'b0;
        dul_master_i.send(dul_pkg::cmd_sw_rst, 4'h0, 10'h000, 6'h00);
        wait_ready();
        for (int i = 0; i < 4; i++) chk_ch(i, 10'h000, 10'h000);
        $display("done: software reset");
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        wait_ready();
        t_power_up();
        t_writes();
        t_mask();
        t_ref();
        t_pin_reset();
        t_sw_reset();
        tally_and_finish();
    end

    // the whole run needs well under 200 cycles
    initial begin
        #(3000 * 50);
        miscompares++;
        tally_and_finish();
    end
endmodule
